// ==== rtl/cgs_pkg.sv ====
// constants, types and register layout of the clock generation and select block
package cgs_pkg;
  localparam int         AW            = 8;
  localparam logic [7:0] OFF_PROT      = 8'h00;
  localparam logic [7:0] OFF_FCTL      = 8'h04;
  localparam logic [7:0] OFF_TRIM      = 8'h08;
  localparam logic [7:0] OFF_FMODE     = 8'h0c;
  localparam logic [7:0] OFF_LPD       = 8'h10;
  localparam logic [7:0] OFF_CTL0      = 8'h14;
  localparam logic [7:0] OFF_CTL1      = 8'h18;
  localparam logic [7:0] OFF_CDET      = 8'h1c;
  localparam logic [7:0] OFF_TRIM_HI   = 8'h20;
  localparam logic [7:0] OFF_TRIM_WIDE = 8'h24;
  localparam logic [7:0] OFF_STAT      = 8'h28;
  // trim data values are arbitrary
  localparam logic [7:0] TRIM_HI_VAL   = 8'h40;
  localparam logic [7:0] TRIM_WIDE_VAL = 8'h48;
  localparam logic [7:0] PROT_WMASK    = 8'h09;
  localparam logic [7:0] FCTL_WMASK    = 8'h03;
  localparam logic [7:0] FMODE_WMASK   = 8'h03;
  localparam logic [7:0] LPD_WMASK     = 8'he1;
  localparam logic [7:0] CTL0_WMASK    = 8'h54;
  localparam logic [7:0] CTL1_WMASK    = 8'hd5;
  localparam logic [7:0] CTL0_RST      = 8'h50;
  localparam logic [7:0] CTL1_RST      = 8'h00;
  localparam int         FCTL_EN_B     = 0;
  localparam int         FCTL_SEL_B    = 1;
  localparam int         CDET_SEL_B    = 2;
  localparam logic [1:0] FMODE_HALF    = 2'h2;
  localparam logic [1:0] RESP_OK       = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam logic [2:0] DIV8_SH       = 3'd3;
  localparam logic [2:0] DIV16_SH      = 3'd4;
  localparam logic [3:0] DIV_WRAP      = 4'hf;
  // oscillator timing, modelled from the 50 MHz reference
  localparam int         CLK_NS        = 20;
  localparam int         FAST_PER_NS   = 125;
  localparam int         SLOW_PER_NS   = 8000;
  localparam int         DET_DLY_US    = 100;
  localparam int         FAST_HALF_CYC = FAST_PER_NS / 2 / CLK_NS;
  localparam int         SLOW_HALF_CYC = SLOW_PER_NS / 2 / CLK_NS;
  localparam int         DET_DLY_DEF   = (DET_DLY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] FAST_LIM      = 4'(FAST_HALF_CYC - 1);
  localparam logic [3:0] FAST_LIM2     = 4'(2 * FAST_HALF_CYC - 1);
  localparam logic [7:0] SLOW_LIM      = 8'(SLOW_HALF_CYC - 1);

  typedef enum logic [1:0] {SRC_SLOW, SRC_FAST, SRC_SUB} cgs_src_t;

  typedef struct packed {
    logic [3:0] rsv_hi;
    logic       lp;
    logic [1:0] rsv_lo;
    logic       clk;
  } cgs_prot_t;

  typedef struct packed {
    logic [2:0] mon_en;
    logic [3:0] rsv;
    logic       ilc;
  } cgs_lpd_t;

  typedef struct packed {
    logic       rsv7;
    logic       div8;
    logic       rsv5;
    logic       pinfn;
    logic       rsv3;
    logic       pws;
    logic [1:0] rsv_lo;
  } cgs_ctl0_t;

  typedef struct packed {
    logic [1:0] div_sel;
    logic       rsv5;
    logic       slow_stop;
    logic       rsv3;
    logic       fb_sel;
    logic       rsv1;
    logic       stop_req;
  } cgs_ctl1_t;

  typedef struct packed {
    logic       cpu;
    logic [4:0] periph;
    logic       osc_periph;
    logic       fast_aux;
    logic       slow_aux;
    logic       sub_div4;
    logic       sub_div32;
  } cgs_clk_t;
endpackage

// ==== rtl/cgs_clock_gen.sv ====
// clock generation, source select and dividers with an AXI4-Lite register slave
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - trim and fast mode registers writable only while clock protect bit is one
// - fast mode value two halves the fast oscillator frequency
// - low-power register writable only while low-power protect bit is set
// - monitor enable rising holds its detector off for the settling delay
// - low-power register survives software, watchdog and monitor resets
// - on-chip oscillator clock taken from fast or slow oscillator
// - oscillator select zero picks slow, one picks fast
// - after any reset cpu clock is slow oscillator divided by eight
// - fast oscillator stopped after reset, runs once its enable is one
// - two read-only trim data registers; first equals trim reset value
// - sub-clock oscillator runs during and after reset
// - sub-clock pin function one starts the sub-clock on its pins
// - system clock select zero picks sub-clock; software waits for stability
// - feedback resistor switchable, cut off automatically in stop mode
// - stop mode halts every clock including the sub-clock
// - cpu clock is system clock divided by 1, 2, 4, 8 or 16
// - divide-by-eight bit overrides; else field 0..3 gives 1, 2, 4, 16
// - stop entry from fast oscillator mode forces divide-by-eight
// - peripheral clocks are system clock divided by 1, 2, 4, 8, 32
// - peripheral wait-stop bit gates divided peripheral clocks in wait
// - oscillator peripheral clock follows on-chip clock, runs in wait
// - fast aux clock from fast oscillator while enabled, runs in wait
// - slow aux clock from slow oscillator when not stopped, runs in wait
// - sub-clock divided by 4 and by 32 provided
module cgs_clock_gen
  import cgs_pkg::*;
#(
  parameter int DET_DLY_CYC = DET_DLY_DEF
) (
  // clock and resets
  input  wire logic          ref_clk_i,
  input  wire logic          reset_i,
  input  wire logic          sys_rst_i,
  // power state
  input  wire logic          wait_i,
  input  wire logic          wake_i,
  input  wire logic          cspro_i,
  // sub-clock pins
  input  wire logic          subclock_in_i,
  output logic               subclock_out_o,
  output logic               subclock_out_en_n_o,
  output logic               feedback_on_o,
  // generated clocks and status
  output cgs_clk_t           clocks_o,
  output logic [7:0]         fast_osc_trim_o,
  output logic               internal_low_consumption_o,
  output logic [2:0]         monitor_active_o,
  output logic               stop_mode_o,
  // axi4-lite slave
  input  wire logic [AW-1:0] axi_awaddr_i,
  input  wire logic          axi_awvalid_i,
  output logic               axi_awready_o,
  input  wire logic [31:0]   axi_wdata_i,
  input  wire logic [3:0]    axi_wstrb_i,
  input  wire logic          axi_wvalid_i,
  output logic               axi_wready_o,
  output logic [1:0]         axi_bresp_o,
  output logic               axi_bvalid_o,
  input  wire logic          axi_bready_i,
  input  wire logic [AW-1:0] axi_araddr_i,
  input  wire logic          axi_arvalid_i,
  output logic               axi_arready_o,
  output logic [31:0]        axi_rdata_o,
  output logic [1:0]         axi_rresp_o,
  output logic               axi_rvalid_o,
  input  wire logic          axi_rready_i
);
  function automatic logic pick(cgs_src_t s, logic slow, logic fast, logic sub);
    logic r;
    r = slow;
    if (s == SRC_FAST) r = fast;
    else if (s == SRC_SUB) r = sub;
    return r;
  endfunction

  function automatic logic mapped(logic [AW-1:0] a);
    return a[1:0] == 2'h0 && a <= OFF_STAT;
  endfunction

  logic            rst_any;
  cgs_prot_t       prot_r;
  logic            fen_r;
  logic            fsel_r;
  logic [7:0]      trim_r;
  logic [1:0]      fmode_r;
  cgs_lpd_t        lpd_r;
  cgs_ctl0_t       ctl0_r, ctl0_wr;
  cgs_ctl1_t       ctl1_r;
  logic            cdet_r;
  logic            aw_ok_r, w_ok_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [AW-1:0]   awaddr_r;
  logic [7:0]      wd;
  logic            wstrb0_r;
  logic [31:0]     wdata_r, rdata_r, rd_word;
  logic [1:0]      bresp_r, rresp_r;
  logic            aw_hs, w_hs, ar_hs, wr_go, wr_en, stop_go;
  logic [3:0]      fast_cnt_r;
  logic            fast_lvl_r, slow_lvl_r, sub_lvl_r, sub_out_r;
  logic [7:0]      slow_cnt_r;
  logic            fast_run, slow_run, sub_run, sub_rise;
  cgs_src_t        src_req, src_act_r;
  logic            sys_lvl_r, sys_nxt, sys_rise, p_gate;
  logic [4:0]      pcnt_r, pcnt_nxt, scnt_r;
  logic [2:0]      div_act_r, div_req;
  logic [2:0]      mon_prev_r, mon_rdy_r;
  logic [15:0]     mon_cnt_r [3];
  cgs_clk_t        clk_r;
  logic            fb_r, pin_en_n_r;

  assign rst_any = reset_i | sys_rst_i;
  assign wd      = wdata_r[7:0];
  assign ctl0_wr = cgs_ctl0_t'(wd & CTL0_WMASK);

  // bus handshakes; a write commits once address and data are both held
  assign aw_hs   = axi_awvalid_i & awready_r;
  assign w_hs    = axi_wvalid_i & wready_r;
  assign ar_hs   = axi_arvalid_i & arready_r;
  assign wr_go   = aw_ok_r & w_ok_r & ~bvalid_r;
  assign wr_en   = wr_go & wstrb0_r;
  assign stop_go = wr_en & awaddr_r == OFF_CTL1 & prot_r.clk & wd[0] & ~cspro_i & ~ctl1_r.stop_req;

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      aw_ok_r   <= 1'b0;
      w_ok_r    <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OK;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
    end else begin
      aw_ok_r   <= ~wr_go & (aw_ok_r | aw_hs);
      w_ok_r    <= ~wr_go & (w_ok_r | w_hs);
      awready_r <= ~aw_hs & (~aw_ok_r | wr_go);
      wready_r  <= ~w_hs & (~w_ok_r | wr_go);
      if (aw_hs) awaddr_r <= axi_awaddr_i;
      if (w_hs) begin
        wdata_r  <= axi_wdata_i;
        wstrb0_r <= axi_wstrb_i[0];
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= mapped(awaddr_r) ? RESP_OK : RESP_SLVERR;
      end else if (axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (axi_araddr_i)
      OFF_PROT:      rd_word[7:0] = prot_r;
      OFF_FCTL:      rd_word[1:0] = {fsel_r, fen_r};
      OFF_TRIM:      rd_word[7:0] = trim_r;
      OFF_FMODE:     rd_word[1:0] = fmode_r;
      OFF_LPD:       rd_word[7:0] = lpd_r;
      OFF_CTL0:      rd_word[7:0] = ctl0_r;
      OFF_CTL1:      rd_word[7:0] = ctl1_r;
      OFF_CDET:      rd_word[CDET_SEL_B] = cdet_r;
      OFF_TRIM_HI:   rd_word[7:0] = TRIM_HI_VAL;
      OFF_TRIM_WIDE: rd_word[7:0] = TRIM_WIDE_VAL;
      OFF_STAT:      rd_word[6:0] = {src_act_r, fast_run, mon_rdy_r, ctl1_r.stop_req};
      default:       rd_word = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OK;
    end else begin
      arready_r <= ~ar_hs & ~(rvalid_r & ~axi_rready_i);
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= mapped(axi_araddr_i) ? RESP_OK : RESP_SLVERR;
      end else if (axi_rready_i) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // clock control registers; a write without its protect bit is dropped quietly
  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      prot_r <= '0;
      fen_r  <= 1'b0;
      fsel_r <= 1'b0;
      trim_r <= TRIM_HI_VAL;
      fmode_r <= '0;
      ctl0_r <= cgs_ctl0_t'(CTL0_RST);
      ctl1_r <= cgs_ctl1_t'(CTL1_RST);
      cdet_r <= 1'b1;
      pin_en_n_r <= 1'b0; // pin function is on out of reset
    end else begin
      if (wr_en) begin
        case (awaddr_r)
          OFF_PROT: prot_r <= cgs_prot_t'(wd & PROT_WMASK);
          OFF_FCTL: if (prot_r.clk) begin
            fen_r  <= wd[FCTL_EN_B];
            fsel_r <= wd[FCTL_SEL_B];
          end
          OFF_TRIM:  if (prot_r.clk) trim_r <= wd;
          OFF_FMODE: if (prot_r.clk) fmode_r <= wd[1:0] & FMODE_WMASK[1:0];
          OFF_CTL0:  if (prot_r.clk) ctl0_r <= ctl0_wr;
          OFF_CTL1:  if (prot_r.clk) begin
            ctl1_r <= cgs_ctl1_t'(wd & CTL1_WMASK);
            // stop request has no effect under count source protection
            ctl1_r.stop_req <= cspro_i ? ctl1_r.stop_req : wd[0];
          end
          OFF_CDET:  if (prot_r.clk) cdet_r <= wd[CDET_SEL_B];
          default: ;
        endcase
      end
      if (stop_go && src_act_r == SRC_FAST) ctl0_r.div8 <= 1'b1;
      // pad enable kept in its own flop so the pin control never passes through logic
      if (wr_en && awaddr_r == OFF_CTL0 && prot_r.clk) pin_en_n_r <= ~ctl0_wr.pinfn;
      if (wake_i) ctl1_r.stop_req <= 1'b0;
    end
  end

  // low-power register sees only the power-on reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      lpd_r <= '0;
    end else if (wr_en && awaddr_r == OFF_LPD && prot_r.lp) begin
      lpd_r <= cgs_lpd_t'(wd & LPD_WMASK);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mon_prev_r <= '0;
      mon_rdy_r  <= '0;
      for (int i = 0; i < 3; i++) mon_cnt_r[i] <= '0;
    end else begin
      mon_prev_r <= lpd_r.mon_en;
      for (int i = 0; i < 3; i++) begin
        if (lpd_r.mon_en[i] && !mon_prev_r[i]) begin
          mon_cnt_r[i] <= 16'(DET_DLY_CYC);
          mon_rdy_r[i] <= 1'b0;
        end else if (mon_cnt_r[i] != 16'h0) begin
          mon_cnt_r[i] <= mon_cnt_r[i] - 16'h1;
        end else begin
          mon_rdy_r[i] <= lpd_r.mon_en[i];
        end
      end
    end
  end

  // oscillator models; stop freezes every source
  assign fast_run = fen_r & ~ctl1_r.stop_req;
  assign slow_run = ~ctl1_r.stop_req & (~ctl1_r.slow_stop | cspro_i | src_act_r == SRC_SLOW);
  assign sub_run  = ctl0_r.pinfn & ~ctl1_r.stop_req;

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      fast_cnt_r <= '0;
      fast_lvl_r <= 1'b0;
    end else if (fast_run) begin
      if (fast_cnt_r >= (fmode_r == FMODE_HALF ? FAST_LIM2 : FAST_LIM)) begin
        fast_cnt_r <= '0;
        fast_lvl_r <= ~fast_lvl_r;
      end else begin
        fast_cnt_r <= fast_cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      slow_cnt_r <= '0;
      slow_lvl_r <= 1'b0;
    end else if (slow_run) begin
      if (slow_cnt_r >= SLOW_LIM) begin
        slow_cnt_r <= '0;
        slow_lvl_r <= ~slow_lvl_r;
      end else begin
        slow_cnt_r <= slow_cnt_r + 8'h1;
      end
    end
  end

  // the pin amplifier keeps running through reset; only a stop request holds its output high and stalls the crystal
  always_ff @(posedge ref_clk_i) begin
    sub_out_r <= ctl1_r.stop_req | ~subclock_in_i;
  end

  assign sub_rise = sub_run & subclock_in_i & ~sub_lvl_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      sub_lvl_r <= 1'b0;
      scnt_r    <= '0;
      fb_r      <= 1'b0;
    end else begin
      if (sub_run) sub_lvl_r <= subclock_in_i;
      if (sub_rise) scnt_r <= scnt_r + 5'h1;
      fb_r <= ~ctl1_r.fb_sel & ~ctl1_r.stop_req;
    end
  end

  // source switch only while both old and new levels are low
  assign src_req  = !cdet_r ? SRC_SUB : (fsel_r ? SRC_FAST : SRC_SLOW);
  assign sys_nxt  = pick(src_act_r, slow_lvl_r, fast_lvl_r, sub_lvl_r);
  assign sys_rise = sys_nxt & ~sys_lvl_r;
  assign pcnt_nxt = sys_rise ? pcnt_r + 5'h1 : pcnt_r;
  assign div_req  = ctl0_r.div8 ? DIV8_SH : (ctl1_r.div_sel == 2'h3 ? DIV16_SH : {1'b0, ctl1_r.div_sel});
  assign p_gate   = wait_i & ctl0_r.pws;

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      src_act_r <= SRC_SLOW;
      sys_lvl_r <= 1'b0;
      pcnt_r    <= '0;
      div_act_r <= DIV8_SH;
    end else begin
      if (src_req != src_act_r && !sys_lvl_r
          && !pick(src_req, slow_lvl_r, fast_lvl_r, sub_lvl_r)) begin
        src_act_r <= src_req;
        sys_lvl_r <= 1'b0;
      end else begin
        sys_lvl_r <= sys_nxt;
      end
      pcnt_r <= pcnt_nxt;
      // divider changes only where every divided phase has just ended
      if (sys_rise && pcnt_r[3:0] == DIV_WRAP) div_act_r <= div_req;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      clk_r <= '0;
    end else begin
      if (!wait_i) clk_r.cpu <= div_act_r == 3'd0 ? sys_nxt : pcnt_nxt[div_act_r - 3'd1];
      if (!p_gate) clk_r.periph <= {pcnt_nxt[4], pcnt_nxt[2:0], sys_nxt};
      clk_r.osc_periph <= fsel_r ? fast_lvl_r : slow_lvl_r;
      clk_r.fast_aux   <= fen_r & fast_lvl_r;
      clk_r.slow_aux   <= (~ctl1_r.slow_stop | cspro_i) & slow_lvl_r;
      clk_r.sub_div4   <= scnt_r[1];
      clk_r.sub_div32  <= scnt_r[4];
    end
  end

  assign clocks_o                   = clk_r;
  assign subclock_out_o             = sub_out_r;
  assign subclock_out_en_n_o        = pin_en_n_r;
  assign feedback_on_o              = fb_r;
  assign fast_osc_trim_o            = trim_r;
  assign internal_low_consumption_o = lpd_r.ilc;
  assign monitor_active_o           = mon_rdy_r;
  assign stop_mode_o                = ctl1_r.stop_req;
  assign axi_awready_o              = awready_r;
  assign axi_wready_o               = wready_r;
  assign axi_bvalid_o               = bvalid_r;
  assign axi_bresp_o                = bresp_r;
  assign axi_arready_o              = arready_r;
  assign axi_rvalid_o               = rvalid_r;
  assign axi_rdata_o                = rdata_r;
  assign axi_rresp_o                = rresp_r;

  trim_prot_a: assert property (@(posedge ref_clk_i) disable iff (rst_any)
    wr_en && awaddr_r == OFF_TRIM && !prot_r.clk |=> $stable(trim_r))
    else $error("trim changed without protect bit");
  lp_prot_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_en && awaddr_r == OFF_LPD && !prot_r.lp |=> $stable(lpd_r))
    else $error("low-power register changed without protect bit");
  mon_delay_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    lpd_r.mon_en[0] && !mon_prev_r[0] |=> !mon_rdy_r[0] [*8])
    else $error("monitor active before settling delay");
  half_rate_a: assert property (@(posedge ref_clk_i) disable iff (rst_any)
    $past(fast_run) && $past(fmode_r) == FMODE_HALF && $changed(fast_lvl_r) |-> $past(fast_cnt_r) == FAST_LIM2)
    else $error("fast half period wrong in halved mode");
  reset_div8_a: assert property (@(posedge ref_clk_i)
    rst_any |=> div_act_r == DIV8_SH && src_act_r == SRC_SLOW)
    else $error("reset did not select slow source divided by eight");
  fast_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_any)
    !fen_r ##1 !fen_r |-> $stable(fast_lvl_r) && !clk_r.fast_aux)
    else $error("fast oscillator runs while disabled");
  stop_div8_a: assert property (@(posedge ref_clk_i) disable iff (rst_any)
    stop_go && !wake_i && src_act_r == SRC_FAST |=> ctl0_r.div8 && ctl1_r.stop_req)
    else $error("stop entry from fast mode kept divider");
  wait_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_any)
    p_gate [*2] |-> $stable(clk_r.periph))
    else $error("peripheral clocks toggled in gated wait");
  stop_halt_a: assert property (@(posedge ref_clk_i) disable iff (rst_any)
    ctl1_r.stop_req [*3] |-> $stable(clk_r.cpu) && $stable(sub_lvl_r) && !fb_r)
    else $error("clock moved during stop");
endmodule
`default_nettype wire

// ==== dv/cgs_clock_gen_tb.sv ====
// self-checking bench for the clock generation and select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module cgs_clock_gen_tb;
  import cgs_pkg::*;
  localparam int DLY = 16;
  localparam int FP  = 2 * FAST_HALF_CYC;
  logic          ref_clk_i = 1'b0;
  logic          reset_i = 1'b1;
  logic          sys_rst_i = 1'b0;
  logic          wait_i = 1'b0;
  logic          wake_i = 1'b0;
  logic          cspro_i = 1'b0;
  logic          subclock_in_i = 1'b0;
  logic [1:0]    sub_cnt = 2'h0;
  logic          subclock_out_o, subclock_out_en_n_o, feedback_on_o, internal_low_consumption_o, stop_mode_o;
  cgs_clk_t      clocks_o;
  logic [7:0]    fast_osc_trim_o;
  logic [2:0]    monitor_active_o;
  logic [AW-1:0] axi_awaddr_i = '0;
  logic [AW-1:0] axi_araddr_i = '0;
  logic [31:0]   axi_wdata_i = '0;
  logic [31:0]   axi_rdata_o;
  logic          axi_awvalid_i = 1'b0, axi_wvalid_i = 1'b0, axi_bready_i = 1'b0, axi_arvalid_i = 1'b0;
  logic          axi_rready_i = 1'b0;
  logic          axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o, axi_rvalid_o;
  logic [1:0]    axi_bresp_o, axi_rresp_o;
  wire logic [10:0] cw;
  int            n_mismatch = 0;
  int            checks_done = 0;
  int            cyc = 0;

  assign cw = clocks_o;

  cgs_clock_gen #(.DET_DLY_CYC(DLY)) dut (
    .ref_clk_i, .reset_i, .sys_rst_i, .wait_i, .wake_i, .cspro_i, .subclock_in_i, .subclock_out_o,
    .subclock_out_en_n_o, .feedback_on_o, .clocks_o, .fast_osc_trim_o, .internal_low_consumption_o,
    .monitor_active_o, .stop_mode_o, .axi_awaddr_i, .axi_awvalid_i, .axi_awready_o, .axi_wdata_i,
    .axi_wstrb_i(4'hf), .axi_wvalid_i, .axi_wready_o, .axi_bresp_o, .axi_bvalid_o, .axi_bready_i,
    .axi_araddr_i, .axi_arvalid_i, .axi_arready_o, .axi_rdata_o, .axi_rresp_o, .axi_rvalid_o, .axi_rready_i
  );

  always #10 ref_clk_i = ~ref_clk_i;

  // crystal pin stands still through reset, then toggles with an 8-cycle period
  always @(posedge ref_clk_i) begin
    if (!reset_i) begin
      sub_cnt <= sub_cnt + 2'h1;
      if (sub_cnt == 2'h3) subclock_in_i <= ~subclock_in_i;
    end
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OK);
    int   n;
    logic aw;
    logic w;
    axi_awaddr_i <= a;
    axi_wdata_i <= {24'h0, d};
    axi_awvalid_i <= 1'b1;
    axi_wvalid_i <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    while (aw || w) begin
      @(posedge ref_clk_i);
      n++;
      if (aw && axi_awready_o === 1'b1) begin
        aw = 1'b0;
        axi_awvalid_i <= 1'b0;
      end
      if (w && axi_wready_o === 1'b1) begin
        w = 1'b0;
        axi_wvalid_i <= 1'b0;
      end
    end
    axi_bready_i <= 1'b1;
    do begin @(posedge ref_clk_i); n++; end while (axi_bvalid_o !== 1'b1);
    axi_bready_i <= 1'b0;
    `CHK($sformatf("bresp %0h", a), er, axi_bresp_o)
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [1:0] er = RESP_OK);
    int n;
    axi_araddr_i <= a;
    axi_arvalid_i <= 1'b1;
    n = 0;
    do begin @(posedge ref_clk_i); n++; end while (axi_arready_o !== 1'b1);
    axi_arvalid_i <= 1'b0;
    axi_rready_i <= 1'b1;
    do begin @(posedge ref_clk_i); n++; end while (axi_rvalid_o !== 1'b1);
    axi_rready_i <= 1'b0;
    `CHK($sformatf("reg %0h", a), ex, axi_rdata_o[7:0])
    `CHK($sformatf("rresp %0h", a), er, axi_rresp_o)
  endtask

  task automatic rise(input int b, output int n);
    n = 0;
    while (cw[b] !== 1'b0 && n < 5000) begin @(posedge ref_clk_i); n++; end
    while (cw[b] !== 1'b1 && n < 10000) begin @(posedge ref_clk_i); n++; end
  endtask

  // settle first: source and divider changes wait for a safe point
  task automatic per(input string nm, input int b, input int ex);
    int n;
    repeat (400) @(posedge ref_clk_i);
    rise(b, n);
    rise(b, n);
    `CHK(nm, ex, n)
  endtask

  task automatic steady(input string nm, input int b, input logic ex);
    logic v;
    int   c;
    // let the edge that samples the new mode pass before taking the reference level
    @(posedge ref_clk_i);
    v = cw[b];
    c = 0;
    repeat (100) begin
      @(posedge ref_clk_i);
      if (cw[b] !== v) c++;
    end
    `CHK(nm, ex, c == 0)
  endtask

  task automatic t_reset;
    repeat (2) @(posedge ref_clk_i);
    `CHK("sub_out_rst", 1'b1, subclock_out_o)
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(OFF_TRIM, TRIM_HI_VAL);
    rd(OFF_TRIM_HI, TRIM_HI_VAL);
    rd(OFF_TRIM_WIDE, TRIM_WIDE_VAL);
    rd(OFF_CTL0, CTL0_RST);
    rd(OFF_STAT, 8'h00);
    rd(8'h2c, 8'h00, RESP_SLVERR);
    wr(8'h2c, 8'h01, RESP_SLVERR);
    `CHK("sub_en_n", 1'b0, subclock_out_en_n_o)
    per("cpu_rst", 10, 16 * SLOW_HALF_CYC);
  endtask

  task automatic t_prot;
    wr(OFF_TRIM, TRIM_WIDE_VAL);
    rd(OFF_TRIM, TRIM_HI_VAL);
    wr(OFF_LPD, 8'h01);
    rd(OFF_LPD, 8'h00);
    wr(OFF_PROT, 8'h09);
    wr(OFF_TRIM, TRIM_WIDE_VAL);
    rd(OFF_TRIM, TRIM_WIDE_VAL);
    `CHK("trim_o", TRIM_WIDE_VAL, fast_osc_trim_o)
    wr(OFF_LPD, 8'h01);
    `CHK("ilc", 1'b1, internal_low_consumption_o)
    wr(OFF_CTL0, 8'h40);
    `CHK("sub_en_off", 1'b1, subclock_out_en_n_o)
    wr(OFF_CTL0, 8'h50);
    `CHK("sub_en_on", 1'b0, subclock_out_en_n_o)
  endtask

  task automatic t_fast;
    int dv[4] = '{1, 2, 4, 16};
    wr(OFF_FCTL, 8'h01);
    rd(OFF_STAT, 8'h10);
    per("fast_aux", 3, FP);
    wr(OFF_FMODE, {6'h0, FMODE_HALF});
    per("fast_half", 3, 2 * FP);
    wr(OFF_FMODE, 8'h00);
    wr(OFF_FCTL, 8'h03);
    per("osc_per", 4, FP);
    per("cpu_d8", 10, 8 * FP);
    wr(OFF_CTL0, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTL1, {i[1:0], 6'h0});
      per($sformatf("cpu_sel%0d", i), 10, dv[i] * FP);
    end
    wr(OFF_CTL1, 8'h00);
    // peripheral vector carries f1 in its lowest bit and f32 in its top bit
    per("f1", 5, FP);
    per("f2", 6, 2 * FP);
    per("f4", 7, 4 * FP);
    per("f8", 8, 8 * FP);
    per("f32", 9, 32 * FP);
    per("slow_aux", 2, 2 * SLOW_HALF_CYC);
  endtask

  task automatic t_src;
    wr(OFF_FCTL, 8'h01);
    per("cpu_slow", 10, 2 * SLOW_HALF_CYC);
    wr(OFF_CDET, 8'h00);
    per("cpu_sub", 10, 8);
    per("sub_div4", 1, 32);
    per("sub_div32", 0, 256);
    wr(OFF_CDET, 8'h04);
    wr(OFF_FCTL, 8'h03);
  endtask

  task automatic t_wait_stop;
    wr(OFF_CTL0, 8'h14);
    wait_i <= 1'b1;
    steady("f1_wait", 5, 1'b1);
    steady("cpu_wait", 10, 1'b1);
    per("osc_wait", 4, FP);
    per("fast_wait", 3, FP);
    wait_i <= 1'b0;
    wr(OFF_CTL0, 8'h10);
    wr(OFF_LPD, 8'h00);
    `CHK("fb_run", 1'b1, feedback_on_o)
    wr(OFF_CTL1, 8'h01);
    @(posedge ref_clk_i);
    `CHK("stop", 1'b1, stop_mode_o)
    `CHK("fb_stop", 1'b0, feedback_on_o)
    steady("cpu_stop", 10, 1'b1);
    steady("fast_stop", 3, 1'b1);
    rd(OFF_CTL0, 8'h50);
    wake_i <= 1'b1;
    @(posedge ref_clk_i);
    wake_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    `CHK("wake", 1'b0, stop_mode_o)
    `CHK("fb_wake", 1'b1, feedback_on_o)
    wr(OFF_CTL1, 8'h04);
    @(posedge ref_clk_i);
    `CHK("fb_off", 1'b0, feedback_on_o)
    wr(OFF_CTL1, 8'h00);
  endtask

  // count source protection keeps the slow clock alive and ignores the stop request
  task automatic t_cspro;
    cspro_i <= 1'b1;
    wr(OFF_CTL1, 8'h11);
    rd(OFF_CTL1, 8'h10);
    per("slow_cspro", 2, 2 * SLOW_HALF_CYC);
    cspro_i <= 1'b0;
    wr(OFF_CTL1, 8'h00);
  endtask

  task automatic t_mon;
    int n;
    wr(OFF_LPD, 8'h20);
    n = 0;
    while (monitor_active_o[0] !== 1'b1 && n < 100) begin @(posedge ref_clk_i); n++; end
    `CHK("mon_dly", 1'b1, n >= DLY - 4 && n <= DLY + 2)
    // software-type reset must leave the low-power register and monitors alone
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(OFF_LPD, 8'h20);
    `CHK("mon_keep", 3'h1, monitor_active_o)
    rd(OFF_TRIM, TRIM_HI_VAL);
    rd(OFF_CTL0, CTL0_RST);
  endtask

  initial begin
    t_reset();
    t_prot();
    t_fast();
    t_src();
    t_wait_stop();
    t_cspro();
    t_mon();
    end_sim();
  end
endmodule
`default_nettype wire
